// >>> dfo_regs.svh
// dfo_regs.svh: configuration offsets, field positions and reset values
// assumes: included by the formatter design files and by the bench
`ifndef DFO_REGS_SVH
`define DFO_REGS_SVH

// ************************************************************
// serial configuration frame
// ************************************************************
`define DFO_FRAME_BITS 5'h10
`define DFO_FRAME_LAST 5'h0F
`define DFO_MODE_ADDR 7'h03

// ************************************************************
// mode control register fields
// ************************************************************
`define DFO_CFG_RST 8'h00
`define DFO_MODE_LSB 0
`define DFO_MODE_MSB 1
`define DFO_PHASE_LSB 2
`define DFO_PHASE_MSB 4

// ************************************************************
// strap capture wait, in clock cycles after reset release
// ************************************************************
`define DFO_STRAP_WAIT 2'h3

`endif

// >>> dfo_pkg.sv
// dfo_pkg: types shared by the output formatter files
// assumes: compiled before every other formatter file
`default_nettype none

package dfo_pkg;

    // output pin format
    typedef enum logic [1:0] {
        DFO_FULL_CMOS = 2'b00,
        DFO_DDR_CMOS = 2'b01,
        DFO_DDR_LVDS = 2'b10
    } dfo_mode_t;

    // serial configuration receiver states
    typedef enum logic [0:0] {
        DFO_SPI_IDLE = 1'b0,
        DFO_SPI_SHIFT = 1'b1
    } dfo_spi_st_t;

    // one channel's sample: result word and its range flag
    typedef struct packed {
        logic [15:0] word;
        logic range;
    } dfo_sample_t;

endpackage : dfo_pkg

`default_nettype wire

// >>> dfo_delay_line.sv
// dfo_delay_line: shift register with a selectable tap
// assumes: sel_in from a register on the same clock
`default_nettype none

module dfo_delay_line #(
    parameter int DEPTH = 8,
    parameter int SEL_W = 3
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // signal and tap select
    input wire logic din_in,
    input wire logic [SEL_W-1:0] sel_in,
    output logic tap_out
);

    logic [DEPTH-2:0] sr_r;
    logic [DEPTH-2:0] sr_nxt;

    // tap 0 is the undelayed input, tap k is k cycles old
    always_comb begin
        sr_nxt = {sr_r[DEPTH-3:0], din_in};
        if (sel_in == '0) begin
            tap_out = din_in;
        end else begin
            tap_out = sr_r[SEL_W'(sel_in - 1'b1)];
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sr_r <= '1;
        end else begin
            sr_r <= sr_nxt;
        end
    end

endmodule : dfo_delay_line

`default_nettype wire

// >>> dfo_spi_cfg.sv
// dfo_spi_cfg: serial write port for the mode control register
// assumes: all inputs already synchronised to clk_in
`include "dfo_regs.svh"
`default_nettype none

module dfo_spi_cfg import dfo_pkg::*; (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // serial port, synchronised
    input wire logic cs_n_in,
    input wire logic sck_in,
    input wire logic sdi_in,
    // configuration
    output logic [7:0] cfg_out
);

    dfo_spi_st_t st_r;
    dfo_spi_st_t st_nxt;
    logic [4:0] cnt_r;
    logic [4:0] cnt_nxt;
    logic [15:0] sh_r;
    logic [15:0] sh_nxt;
    logic sck_q_r;
    logic [7:0] cfg_r;
    logic [7:0] cfg_nxt;
    logic sck_rise;

    assign sck_rise = sck_in & ~sck_q_r;
    assign cfg_out = cfg_r;

    // frame: write flag low, 7-bit address, 8-bit data, msb first
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        cfg_nxt = cfg_r;
        case (st_r)
            DFO_SPI_IDLE: begin
                if (!cs_n_in) begin
                    st_nxt = DFO_SPI_SHIFT;
                    cnt_nxt = 5'h00;
                end
            end
            DFO_SPI_SHIFT: begin
                if (cs_n_in) begin
                    st_nxt = DFO_SPI_IDLE;
                end else if (sck_rise) begin
                    sh_nxt = {sh_r[14:0], sdi_in};
                    cnt_nxt = cnt_r + 5'h01;
                    if (cnt_r == `DFO_FRAME_LAST) begin
                        cnt_nxt = 5'h00;
                        if (sh_nxt[15:8] == {1'b0, `DFO_MODE_ADDR}) begin
                            cfg_nxt = sh_nxt[7:0]; // [RULE13]
                        end
                    end
                end
            end
            default: begin
                st_nxt = DFO_SPI_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_r <= DFO_SPI_IDLE;
            cnt_r <= 5'h00;
            sh_r <= 16'h0000;
            sck_q_r <= 1'b0;
            cfg_r <= `DFO_CFG_RST;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            sck_q_r <= sck_in;
            cfg_r <= cfg_nxt;
        end
    end

    property p_cfg_commit;
        @(posedge clk_in) disable iff (!rst_n_in)
        st_r == DFO_SPI_SHIFT && !cs_n_in && sck_rise
            && cnt_r == `DFO_FRAME_LAST && !sh_r[14]
            && sh_r[13:7] == `DFO_MODE_ADDR
        |=> cfg_r == {$past(sh_r[6:0]), $past(sdi_in)};
    endproperty
    a_cfg_commit: assert property (p_cfg_commit) // [RULE13]
        else $error("mode register not written by serial frame");

endmodule : dfo_spi_cfg

`default_nettype wire

// >>> dfo_top.sv
// dfo_top: dual channel sample output formatter
// assumes: converter core words and encode clock arrive asynchronously
// Contract
// RULE1 - both channels captured on one encode edge, 16-bit word each
// RULE2 - complementary clock output is always the inverse of true clock
// RULE3 - full-rate outputs change with falling edge of forwarded clock
// RULE4 - full-rate: 16 separate pins per channel, bit 15 is msb
// RULE5 - full-rate: channel 1 flag high for out-of-range sample
// RULE6 - full-rate: channel 2 flag high for out-of-range sample
// RULE7 - ddr cmos: two bits per pin, eight pins per channel
// RULE8 - ddr: even bits while clock low, odd bits while high
// RULE9 - ddr lvds: two bits per pair, eight pairs, same phases
// RULE10 - ddr: data changes on both forwarded clock edges
// RULE11 - ddr: merged flag shows channel 2 when low, channel 1 high
// RULE12 - forwarded clock phase delay is configurable
// RULE13 - mode and phase come from serially written mode register
// RULE14 - range flag has the same latency as its data word
// RULE15 - mode from register, or strap pin where ddr cmos is barred
// RULE16 - receiver captures both halves, rebuilds words, splits flags
`include "dfo_regs.svh"
`default_nettype none

module dfo_top import dfo_pkg::*; #(
    parameter int PHASE_DEPTH = 8
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // converter core
    input wire logic enc_clk_in,
    input wire logic [15:0] conv_ch1_word_in,
    input wire logic conv_ch1_range_in,
    input wire logic [15:0] conv_ch2_word_in,
    input wire logic conv_ch2_range_in,
    // configuration pins
    input wire logic config_style_pin_in,
    input wire logic spi_cs_n_in,
    input wire logic spi_sck_in,
    input wire logic spi_sdi_in,
    // full-rate pins
    output logic [15:0] ch1_word_pins_out,
    output logic [15:0] ch2_word_pins_out,
    output logic ch1_range_flag_out,
    output logic ch2_range_flag_out,
    // double data rate pins
    output logic [7:0] ch1_pair_pins_out,
    output logic [7:0] ch2_pair_pins_out,
    output logic merged_range_flag_out,
    output logic lvds_en_out,
    // forwarded clock
    output logic fwd_clk_true_out,
    output logic fwd_clk_comp_out
);

    localparam int SYNC_W = 39;

    function automatic logic [7:0] even_bits(input logic [15:0] w);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = w[2*i];
        end
        return r;
    endfunction : even_bits

    function automatic logic [7:0] odd_bits(input logic [15:0] w);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = w[2*i+1];
        end
        return r;
    endfunction : odd_bits

    // ************************************************************
    // reset release and input synchronisers
    // ************************************************************
    logic rst_s1_r;
    logic rst_n;
    logic [SYNC_W-1:0] sync1_r;
    logic [SYNC_W-1:0] sync2_r;

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_s1_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n <= rst_s1_r;
        end
    end

    // converter words assumed to hold steady around each encode edge
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= {enc_clk_in, conv_ch1_word_in, conv_ch1_range_in,
                conv_ch2_word_in, conv_ch2_range_in, config_style_pin_in,
                spi_cs_n_in, spi_sck_in, spi_sdi_in};
            sync2_r <= sync1_r;
        end
    end

    logic enc_s;
    dfo_sample_t raw1;
    dfo_sample_t raw2;
    logic style_s;
    logic cs_n_s;
    logic sck_s;
    logic sdi_s;
    assign {enc_s, raw1, raw2, style_s, cs_n_s, sck_s, sdi_s} = sync2_r;

    // ************************************************************
    // configuration and mode selection
    // ************************************************************
    logic [7:0] cfg;
    logic [1:0] strap_cnt_r;
    logic [1:0] strap_cnt_nxt;
    logic style_r;
    logic style_nxt;
    dfo_mode_t mode_r;
    dfo_mode_t mode_nxt;
    logic [2:0] phase_r;
    logic [2:0] phase_nxt;

    dfo_spi_cfg u_spi (
        .clk_in(ref_clk_in),
        .rst_n_in(rst_n),
        .cs_n_in(cs_n_s),
        .sck_in(sck_s),
        .sdi_in(sdi_s),
        .cfg_out(cfg)
    );

    // strap sampled once, after the synchroniser has filled
    always_comb begin
        strap_cnt_nxt = strap_cnt_r;
        style_nxt = style_r;
        if (strap_cnt_r != `DFO_STRAP_WAIT) begin
            strap_cnt_nxt = strap_cnt_r + 2'h1;
            if (strap_cnt_nxt == `DFO_STRAP_WAIT) begin
                style_nxt = style_s;
            end
        end
        // pin style: sck level picks the mode, no ddr cmos
        if (style_r) begin
            mode_nxt = sck_s ? DFO_DDR_LVDS : DFO_FULL_CMOS; // [RULE15]
            phase_nxt = 3'h0;
        end else begin
            case (cfg[`DFO_MODE_MSB:`DFO_MODE_LSB]) // [RULE13]
                2'b01: mode_nxt = DFO_DDR_CMOS;
                2'b10: mode_nxt = DFO_DDR_LVDS;
                default: mode_nxt = DFO_FULL_CMOS;
            endcase
            phase_nxt = cfg[`DFO_PHASE_MSB:`DFO_PHASE_LSB];
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            strap_cnt_r <= 2'h0;
            style_r <= 1'b0;
            mode_r <= DFO_FULL_CMOS;
            phase_r <= 3'h0;
        end else begin
            strap_cnt_r <= strap_cnt_nxt;
            style_r <= style_nxt;
            mode_r <= mode_nxt;
            phase_r <= phase_nxt;
        end
    end

    // ************************************************************
    // sample capture and pin formatting
    // ************************************************************
    logic enc_q_r;
    logic base_r;
    logic base_nxt;
    logic enc_rise;
    dfo_sample_t smp1_r;
    dfo_sample_t smp1_nxt;
    dfo_sample_t smp2_r;
    dfo_sample_t smp2_nxt;
    logic [15:0] w1_nxt;
    logic [15:0] w2_nxt;
    logic f1_nxt;
    logic f2_nxt;
    logic [7:0] p1_nxt;
    logic [7:0] p2_nxt;
    logic mf_nxt;
    logic dly_tap;

    assign enc_rise = enc_s & ~enc_q_r;

    always_comb begin
        // base clock falls on the encode edge that takes a sample
        base_nxt = ~enc_s;
        smp1_nxt = smp1_r;
        smp2_nxt = smp2_r;
        if (enc_rise) begin
            smp1_nxt = raw1; // [RULE1]
            smp2_nxt = raw2; // [RULE1]
        end
        w1_nxt = 16'h0000;
        w2_nxt = 16'h0000;
        f1_nxt = 1'b0;
        f2_nxt = 1'b0;
        p1_nxt = 8'h00;
        p2_nxt = 8'h00;
        mf_nxt = 1'b0;
        if (mode_r == DFO_FULL_CMOS) begin
            w1_nxt = ch1_word_pins_out;
            w2_nxt = ch2_word_pins_out;
            f1_nxt = ch1_range_flag_out;
            f2_nxt = ch2_range_flag_out;
            if (enc_rise) begin
                w1_nxt = smp1_nxt.word; // [RULE3] [RULE4]
                w2_nxt = smp2_nxt.word; // [RULE4]
                f1_nxt = smp1_nxt.range; // [RULE5] [RULE14]
                f2_nxt = smp2_nxt.range; // [RULE6]
            end
        end else begin
            // half the base period per bit, both edges used
            if (base_nxt) begin
                p1_nxt = odd_bits(smp1_nxt.word); // [RULE8] [RULE10]
                p2_nxt = odd_bits(smp2_nxt.word); // [RULE7] [RULE9]
                mf_nxt = smp1_nxt.range; // [RULE11]
            end else begin
                p1_nxt = even_bits(smp1_nxt.word); // [RULE8]
                p2_nxt = even_bits(smp2_nxt.word); // [RULE7] [RULE9]
                mf_nxt = smp2_nxt.range; // [RULE11] [RULE14]
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            enc_q_r <= 1'b0;
            base_r <= 1'b1;
            smp1_r <= '0;
            smp2_r <= '0;
            ch1_word_pins_out <= 16'h0000;
            ch2_word_pins_out <= 16'h0000;
            ch1_range_flag_out <= 1'b0;
            ch2_range_flag_out <= 1'b0;
            ch1_pair_pins_out <= 8'h00;
            ch2_pair_pins_out <= 8'h00;
            merged_range_flag_out <= 1'b0;
            lvds_en_out <= 1'b0;
            fwd_clk_true_out <= 1'b1;
            fwd_clk_comp_out <= 1'b0;
        end else begin
            enc_q_r <= enc_s;
            base_r <= base_nxt;
            smp1_r <= smp1_nxt;
            smp2_r <= smp2_nxt;
            ch1_word_pins_out <= w1_nxt;
            ch2_word_pins_out <= w2_nxt;
            ch1_range_flag_out <= f1_nxt;
            ch2_range_flag_out <= f2_nxt;
            ch1_pair_pins_out <= p1_nxt;
            ch2_pair_pins_out <= p2_nxt;
            merged_range_flag_out <= mf_nxt;
            lvds_en_out <= (mode_r == DFO_DDR_LVDS); // [RULE9]
            fwd_clk_true_out <= dly_tap;
            fwd_clk_comp_out <= ~dly_tap; // [RULE2]
        end
    end

    // ************************************************************
    // forwarded clock phase delay
    // ************************************************************
    // delay step is one reference period, coarse but glitch free
    dfo_delay_line #(
        .DEPTH(PHASE_DEPTH),
        .SEL_W(3)
    ) u_dly (
        .clk_in(ref_clk_in),
        .rst_n_in(rst_n),
        .din_in(base_nxt),
        .sel_in(phase_r), // [RULE12]
        .tap_out(dly_tap)
    );

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n);

    property p_clk_comp;
        fwd_clk_comp_out == ~fwd_clk_true_out;
    endproperty
    a_clk_comp: assert property (p_clk_comp) // [RULE2]
        else $error("complement clock not inverse of true clock");

    property p_sample_both;
        enc_rise |=> smp1_r == $past(raw1) && smp2_r == $past(raw2);
    endproperty
    a_sample_both: assert property (p_sample_both) // [RULE1]
        else $error("channels not sampled on the same encode edge");

    property p_full_edge;
        $past(mode_r) == DFO_FULL_CMOS && $past(mode_r, 2) == DFO_FULL_CMOS
            && $changed(ch1_word_pins_out) |-> $fell(base_r);
    endproperty
    a_full_edge: assert property (p_full_edge) // [RULE3]
        else $error("full-rate data moved off the falling clock edge");

    property p_full_word;
        $past(mode_r) == DFO_FULL_CMOS && $fell(base_r)
            |-> ch1_word_pins_out == smp1_r.word
                && ch2_word_pins_out == smp2_r.word;
    endproperty
    a_full_word: assert property (p_full_word) // [RULE4]
        else $error("full-rate word pins do not show the sample");

    property p_flag1;
        $past(mode_r) == DFO_FULL_CMOS && $fell(base_r)
            |-> ch1_range_flag_out == smp1_r.range;
    endproperty
    a_flag1: assert property (p_flag1) // [RULE5]
        else $error("channel 1 range flag wrong");

    property p_flag2;
        $past(mode_r) == DFO_FULL_CMOS && $fell(base_r)
            |-> ch2_range_flag_out == smp2_r.range;
    endproperty
    a_flag2: assert property (p_flag2) // [RULE6]
        else $error("channel 2 range flag wrong");

    property p_ddr_cmos;
        $past(mode_r) == DFO_DDR_CMOS
            |-> ch1_word_pins_out == 16'h0000 && !lvds_en_out;
    endproperty
    a_ddr_cmos: assert property (p_ddr_cmos) // [RULE7]
        else $error("ddr cmos mode drives full-rate pins");

    property p_ddr_phase;
        $past(mode_r) != DFO_FULL_CMOS |->
            (base_r ? ch1_pair_pins_out == odd_bits(smp1_r.word)
                : ch1_pair_pins_out == even_bits(smp1_r.word));
    endproperty
    a_ddr_phase: assert property (p_ddr_phase) // [RULE8]
        else $error("ddr bit not on its clock phase");

    property p_lvds;
        $past(mode_r) == DFO_DDR_LVDS |-> lvds_en_out
            && ch2_pair_pins_out == (base_r ? odd_bits(smp2_r.word)
                : even_bits(smp2_r.word));
    endproperty
    a_lvds: assert property (p_lvds) // [RULE9]
        else $error("lvds pairs wrong");

    property p_ddr_stable;
        $past(mode_r) != DFO_FULL_CMOS && $past(mode_r, 2) != DFO_FULL_CMOS
            && $stable(base_r) |-> $stable(ch1_pair_pins_out);
    endproperty
    a_ddr_stable: assert property (p_ddr_stable) // [RULE10]
        else $error("ddr data changed between clock edges");

    property p_merged;
        $past(mode_r) != DFO_FULL_CMOS |-> merged_range_flag_out
            == (base_r ? smp1_r.range : smp2_r.range);
    endproperty
    a_merged: assert property (p_merged) // [RULE11]
        else $error("merged range flag shows wrong channel");

    property p_phase0;
        $past(phase_r) == 3'h0 |-> fwd_clk_true_out == base_r;
    endproperty
    a_phase0: assert property (p_phase0) // [RULE12]
        else $error("undelayed forwarded clock misaligned");

    property p_phase2;
        $past(phase_r) == 3'h2 && $past(phase_r, 2) == 3'h2
            |-> fwd_clk_true_out == $past(base_r, 2);
    endproperty
    a_phase2: assert property (p_phase2) // [RULE12]
        else $error("forwarded clock delay not two cycles");

    property p_latency;
        $past(mode_r) != DFO_FULL_CMOS && $fell(base_r)
            |-> merged_range_flag_out == smp2_r.range
                && ch2_pair_pins_out == even_bits(smp2_r.word);
    endproperty
    a_latency: assert property (p_latency) // [RULE14]
        else $error("flag and word from different samples");

    property p_strap;
        style_r |-> mode_r != DFO_DDR_CMOS;
    endproperty
    a_strap: assert property (p_strap) // [RULE15]
        else $error("ddr cmos selected under pin configuration");

    c_full: cover property ($past(mode_r) == DFO_FULL_CMOS && $fell(base_r));
    c_ddr_cmos: cover property (mode_r == DFO_DDR_CMOS && $rose(base_r));
    c_lvds: cover property (mode_r == DFO_DDR_LVDS && $fell(base_r));
    c_phase: cover property (phase_r != 3'h0 && $rose(fwd_clk_true_out));

endmodule : dfo_top

`default_nettype wire

// >>> dfo_rx_model.sv
// dfo_rx_model: receiver that rebuilds samples from the formatter pins
// assumes: runs on the formatter's ref clock; ddr capture needs phase 0
`default_nettype none

module dfo_rx_model (
    // clock and mode
    input wire logic clk_in,
    input wire logic ddr_in,
    // formatter pins
    input wire logic fclk_in,
    input wire logic [15:0] w1_in,
    input wire logic [15:0] w2_in,
    input wire logic f1_in,
    input wire logic f2_in,
    input wire logic [7:0] p1_in,
    input wire logic [7:0] p2_in,
    input wire logic fm_in,
    // rebuilt samples
    output logic [15:0] w1_out,
    output logic [15:0] w2_out,
    output logic f1_out,
    output logic f2_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic prev_r;
    logic [7:0] e1_r, e2_r;
    logic ef_r;

    function automatic logic [15:0] mix(input logic [7:0] ev,
                                        input logic [7:0] od);
        logic [15:0] w;
        for (int i = 0; i < 8; i++) begin
            w[2*i] = ev[i];
            w[2*i+1] = od[i];
        end
        return w;
    endfunction : mix

    // ************************************************************
    // capture: low half held until the rise, then words rebuilt
    // ************************************************************
    always @(posedge clk_in) begin
        prev_r <= fclk_in;
        if (!ddr_in) begin
            if (fclk_in && !prev_r) begin
                w1_out <= w1_in;
                w2_out <= w2_in;
                f1_out <= f1_in;
                f2_out <= f2_in;
            end
        end else if (!fclk_in) begin
            e1_r <= p1_in;
            e2_r <= p2_in;
            ef_r <= fm_in;
        end else if (!prev_r) begin
            w1_out <= mix(e1_r, p1_in);
            w2_out <= mix(e2_r, p2_in);
            f1_out <= fm_in;
            f2_out <= ef_r;
        end
    end
endmodule : dfo_rx_model

`default_nettype wire

// >>> tb.sv
// tb: self-checking bench of the dual channel output formatter
// assumes: dfo_pkg and the design files compiled first
`include "dfo_regs.svh"
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_in = 1'b0, rst_n_in = 1'b0, enc_clk_in = 1'b0;
    logic [15:0] conv_ch1_word_in = 16'h0000, conv_ch2_word_in = 16'h0000;
    logic conv_ch1_range_in = 1'b0, conv_ch2_range_in = 1'b0;
    logic config_style_pin_in = 1'b0, spi_cs_n_in = 1'b1;
    logic spi_sck_in = 1'b0, spi_sdi_in = 1'b0, ddr = 1'b0;
    logic [15:0] ch1_word_pins_out, ch2_word_pins_out, rw1, rw2;
    logic [7:0] ch1_pair_pins_out, ch2_pair_pins_out;
    logic ch1_range_flag_out, ch2_range_flag_out, merged_range_flag_out;
    logic lvds_en_out, fwd_clk_true_out, fwd_clk_comp_out, rf1, rf2;
    int n_fail = 0, n_tests = 0;
    logic [31:0] seed = 32'h00000EEC;

    initial begin
        forever #2 ref_clk_in = ~ref_clk_in;
    end

    dfo_top #(.PHASE_DEPTH(8)) i_dut (.ref_clk_in, .rst_n_in, .enc_clk_in,
        .conv_ch1_word_in, .conv_ch1_range_in, .conv_ch2_word_in,
        .conv_ch2_range_in, .config_style_pin_in, .spi_cs_n_in, .spi_sck_in,
        .spi_sdi_in, .ch1_word_pins_out, .ch2_word_pins_out,
        .ch1_range_flag_out, .ch2_range_flag_out, .ch1_pair_pins_out,
        .ch2_pair_pins_out, .merged_range_flag_out, .lvds_en_out,
        .fwd_clk_true_out, .fwd_clk_comp_out);
    dfo_rx_model i_rx (.clk_in(ref_clk_in), .ddr_in(ddr),
        .fclk_in(fwd_clk_true_out), .w1_in(ch1_word_pins_out),
        .w2_in(ch2_word_pins_out), .f1_in(ch1_range_flag_out),
        .f2_in(ch2_range_flag_out), .p1_in(ch1_pair_pins_out),
        .p2_in(ch2_pair_pins_out), .fm_in(merged_range_flag_out),
        .w1_out(rw1), .w2_out(rw2), .f1_out(rf1), .f2_out(rf2));

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xs
    function automatic logic [7:0] odd(input logic [15:0] w);
        logic [7:0] o;
        for (int i = 0; i < 8; i++) begin
            o[i] = w[2*i+1];
        end
        return o;
    endfunction : odd
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask : cyc
    task automatic chk16(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %0t word got %h exp %h", $time, g, e);
        end
    endtask : chk16
    task automatic chk1(input logic g, input logic e);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %0t bit got %b exp %b", $time, g, e);
        end
    endtask : chk1
    task automatic close_out();
        $display("tests %0d fails %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out
    task automatic rst(input logic sty, input logic sk);
        rst_n_in = 1'b0;
        config_style_pin_in = sty;
        spi_sck_in = sk;
        cyc(12);
        rst_n_in = 1'b1;
        cyc(10);
    endtask : rst
    task automatic spi(input logic [15:0] f);
        spi_cs_n_in = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            spi_sdi_in = f[i];
            cyc(4);
            spi_sck_in = 1'b1;
            cyc(4);
            spi_sck_in = 1'b0;
        end
        cyc(4);
        spi_cs_n_in = 1'b1;
        cyc(8);
    endtask : spi
    task automatic cfg(input logic [1:0] m, input logic [2:0] p);
        spi({1'b0, `DFO_MODE_ADDR, 3'b000, p, m});
    endtask : cfg
    // ************************************************************
    // one encode period, then both output paths checked
    // ************************************************************
    task automatic samp(input logic [15:0] a, input logic [15:0] b,
                        input logic ra, input logic rb);
        conv_ch1_word_in = a;
        conv_ch2_word_in = b;
        conv_ch1_range_in = ra;
        conv_ch2_range_in = rb;
        cyc(4);
        enc_clk_in = 1'b1;
        cyc(8);
        enc_clk_in = 1'b0;
        cyc(4);
        chk16(rw1, a);
        chk16(rw2, b);
        chk1(rf1, ra);
        chk1(rf2, rb);
        if (ddr) begin
            chk16({8'h00, ch1_pair_pins_out}, {8'h00, odd(a)});
            chk16({8'h00, ch2_pair_pins_out}, {8'h00, odd(b)});
        end else begin
            chk16(ch1_word_pins_out, a);
            chk16(ch2_word_pins_out, b);
            chk1(ch1_range_flag_out, ra);
            chk1(ch2_range_flag_out, rb);
        end
    endtask : samp
    task automatic burst(input int n);
        samp(16'hFFFF, 16'h0000, 1'b1, 1'b0);
        samp(16'h0000, 16'hFFFF, 1'b0, 1'b1);
        repeat (n) begin
            seed = xs(seed);
            samp(seed[15:0], seed[31:16], seed[3], seed[20]);
        end
        $display("burst done ddr=%b lvds=%b", ddr, lvds_en_out);
    endtask : burst
    // cycles from the word update to the forwarded clock fall
    task automatic ph(input logic [2:0] p);
        int n;
        int k;
        logic [15:0] a;
        cfg(2'b00, p);
        ddr = 1'b0;
        a = ~ch1_word_pins_out;
        conv_ch1_word_in = a;
        cyc(4);
        enc_clk_in = 1'b1;
        n = 0;
        k = 0;
        while (ch1_word_pins_out !== a && n < 20) begin
            cyc(1);
            n++;
        end
        while (fwd_clk_true_out !== 1'b0 && k < 20) begin
            cyc(1);
            k++;
        end
        chk16(ch1_word_pins_out, a);
        chk16(16'(k), {13'h0000, p});
        cyc(8);
        enc_clk_in = 1'b0;
        cyc(10);
        $display("phase %0d done", p);
    endtask : ph

    always @(negedge ref_clk_in) begin
        if (rst_n_in) begin
            chk1(fwd_clk_comp_out, ~fwd_clk_true_out);
        end
    end

    initial begin
        rst(1'b0, 1'b0);
        chk16(ch1_word_pins_out, 16'h0000);
        chk1(lvds_en_out, 1'b0);
        burst(6);
        ph(3'd7);
        ph(3'd2);
        ph(3'd0);
        cfg(2'b01, 3'd0);
        ddr = 1'b1;
        chk1(lvds_en_out, 1'b0);
        burst(6);
        cfg(2'b10, 3'd0);
        chk1(lvds_en_out, 1'b1);
        burst(6);
        spi({1'b0, 7'h04, 8'h00});
        spi({1'b1, `DFO_MODE_ADDR, 8'h00});
        chk1(lvds_en_out, 1'b1);
        cfg(2'b11, 3'd0);
        ddr = 1'b0;
        chk1(lvds_en_out, 1'b0);
        burst(3);
        rst(1'b1, 1'b1);
        ddr = 1'b1;
        chk1(lvds_en_out, 1'b1);
        burst(3);
        rst(1'b1, 1'b0);
        ddr = 1'b0;
        chk1(lvds_en_out, 1'b0);
        burst(2);
        close_out();
    end
endmodule : tb

`default_nettype wire
